// ===== dv/adc_link_asserts.sv
/*
  checker on the link pins between converter end and host end.
  assumes one clock, synchronous active-high reset, pins sampled at posedge.
*/
`timescale 1ns/1ns
module adc_link_asserts (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // link pins
  input  wire logic        conversion_start_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        power_down_n,
  input  wire logic        shutdown_level_select,
  input  wire logic        busy_n,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // a shutdown may cut a conversion short, so it lifts this check
  a_busy_span_exact: assert property (@(posedge i_mclk) disable iff (i_rst || !power_down_n)
    $fell(busy_n) |-> !busy_n [*7] ##1 busy_n)
    else $error("busy low span is not seven cycles");
  a_start_causes_busy: assert property ($fell(busy_n) |-> !$past(chip_select_n, 5) &&
    (!$past(conversion_start_n, 4) || !$past(conversion_start_n, 5) ||
     !$past(conversion_start_n, 6)))
    else $error("conversion began without a selected start edge");
  // a start landing in the last acquisition cycle leaves status high one cycle only
  a_acquire_gap: assert property (conversion_start_n ##1
    ($fell(conversion_start_n) && !chip_select_n && power_down_n) ##1
    !conversion_start_n ##3 ($rose(busy_n) && power_down_n) |=> !busy_n)
    else $error("start at the end of acquisition was not taken");
  a_start_spacing: assert property ($fell(busy_n) |=> (!$fell(busy_n)) [*7])
    else $error("conversion restarted too early");

  // ----------------------------------------------------------------
  // result and output enable
  // ----------------------------------------------------------------
  a_result_held: assert property (!busy_n |-> $stable(data_out))
    else $error("result changed during conversion");
  a_result_at_done: assert property ($changed(data_out) |-> $rose(busy_n))
    else $error("result changed away from conversion end");
  a_oe_on_read: assert property ((!chip_select_n && !read_n && power_down_n) [*7] |-> data_oe)
    else $error("outputs not driven while selected and read");
  a_oe_off_idle: assert property ((chip_select_n || read_n) [*7] |-> !data_oe)
    else $error("outputs driven without read strobe");
  a_shutdown_idle: assert property ((!power_down_n) [*8] |-> busy_n)
    else $error("converting while shut down");
endmodule : adc_link_asserts

// ===== dv/sampling_converter_conversion_control_tb.sv
/*
  testbench joining converter end and host end through the link interface.
  assumes a 10 mhz clock; deep wake count shortened to keep the run brief.
*/
`timescale 1ns/1ns
module sampling_converter_conversion_control_tb;
  import adc_ctl_pkg::*;

  localparam int          WAKE     = 20;
  localparam logic [11:0] CODES[5] = '{12'h800, 12'h7ff, 12'h000, 12'hfff, 12'h5a3};

  logic        i_mclk;
  logic        i_rst;
  logic [11:0] i_sample;
  host_mode_t  i_mode;
  logic        i_start;
  logic        i_power_down;
  logic        i_shutdown_light;
  logic [11:0] dev_result;
  logic [11:0] host_result;
  logic        analog_on;
  logic        ref_on;
  logic        sd_light;
  logic        sd_deep;
  logic        host_valid;
  logic        host_ready;
  logic        dev_valid;
  logic        dev_conv;
  int          done_cnt;
  int          conv_cnt;
  logic [11:0] last;
  int          fail_count;
  int          checks_done;

  adc_link_if link ();

  adc_device_end #(.SLEEP_WAKE_CYCLES(WAKE)) u_adc_device_end (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .link(link), .i_sample(i_sample),
    .o_result(dev_result), .o_result_valid(dev_valid), .o_converting(dev_conv),
    .o_analog_on(analog_on),
    .o_reference_on(ref_on), .o_shutdown_light(sd_light), .o_shutdown_deep(sd_deep));

  adc_host_end #(.SLEEP_WAKE_CYCLES(WAKE)) u_adc_host_end (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .link(link), .i_mode(i_mode),
    .i_start(i_start), .i_power_down(i_power_down), .i_shutdown_light(i_shutdown_light),
    .o_result(host_result), .o_result_valid(host_valid), .o_ready(host_ready));

  adc_link_asserts u_adc_link_asserts (
    .i_mclk(i_mclk), .i_rst(i_rst), .conversion_start_n(link.conversion_start_n),
    .chip_select_n(link.chip_select_n), .read_n(link.read_n),
    .power_down_n(link.power_down_n), .shutdown_level_select(link.shutdown_level_select),
    .busy_n(link.busy_n), .data_out(link.data_out), .data_oe(link.data_oe));

  initial i_mclk = 1'b0;
  always #50 i_mclk = ~i_mclk;

  // counts finished conversions and cycles spent converting, seen at the device
  always @(posedge i_mclk)
  begin
    if (dev_valid === 1'b1)
      done_cnt++;
    if (dev_conv === 1'b1)
      conv_cnt++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // a style change may fire one stray conversion, so let it settle first
  task automatic convert(input host_mode_t m, input logic [11:0] s, input logic [11:0] exp);
    int n;
    int d0;
    int c0;
    if (i_mode != m)
    begin
      i_mode = m;
      repeat (20) @(negedge i_mclk);
    end
    n = 0;
    while (host_ready !== 1'b1 && n < 200)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk({11'h000, host_ready}, 12'h001);
    d0 = done_cnt;
    c0 = conv_cnt;
    i_sample = s;
    i_start  = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    n = 0;
    while (host_valid !== 1'b1 && n < 100)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk({11'h000, host_valid}, 12'h001);
    chk(host_result, exp);
    // in rom style the result comes back before the conversion ends
    n = 0;
    while (host_ready !== 1'b1 && n < 100)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk(dev_result, s);
    chk(12'(done_cnt - d0), 12'h001);
    chk(12'(conv_cnt - c0), 12'(CONV_CYC));
  endtask : convert

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_rst = 1'b1;
    i_sample = 12'h000;
    i_mode = MODE_FREE_LOW_PULSE;
    i_start = 1'b0;
    i_power_down = 1'b0;
    i_shutdown_light = 1'b1;
    last = 12'h000;
    fail_count = 0;
    checks_done = 0;
    done_cnt = 0;
    conv_cnt = 0;
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    // every style once, the first four with the extreme codes
    for (int k = 0; k < 5; k++)
    begin
      convert(host_mode_t'(k), CODES[k], (k == 4) ? last : CODES[k]);
      last = CODES[k];
    end
    // rom reads back to back, each returning the one before
    convert(MODE_ROM, 12'h123, last);
    convert(MODE_ROM, 12'h456, 12'h123);
    convert(MODE_FREE_LOW_PULSE, 12'h9ab, 12'h9ab);
    convert(MODE_FREE_LOW_PULSE, 12'h9ac, 12'h9ac);
    $display("test styles done");
    // light then deep shutdown, each followed by a conversion after wake
    for (int l = 1; l >= 0; l--)
    begin
      i_shutdown_light = l[0];
      i_power_down = 1'b1;
      repeat (12) @(negedge i_mclk);
      chk({8'h00, analog_on, ref_on, sd_light, sd_deep}, {9'h000, l[0], l[0], ~l[0]});
      i_power_down = 1'b0;
      convert(MODE_FREE_LOW_PULSE, {11'h1e0, l[0]}, {11'h1e0, l[0]});
      chk({11'h000, analog_on}, 12'h001);
    end
    $display("test shutdown done");
    conclude();
  end

  // watchdog: the tests need a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    conclude();
  end
endmodule : sampling_converter_conversion_control_tb

// ===== logic/adc_ctl_pkg.sv
/*
  constants, types and timing counts shared by both ends of the converter link.
  assumes a single 10 mhz clock shared by both ends; pins still cross through
  three-flop filters because they behave as board wires.
*/
// Behaviour
// - conversion completes within 0.65us typ, 0.75us max
// - next sample acquired within 100ns after conversion
// - starts may repeat every 800ns, 1.25Msps
// - light shutdown keeps logic and reference powered
// - host waits 200ns after light shutdown release
// - host waits 10ms after deep shutdown release
// - power-down input low means shutdown, high runs
// - level select high light, low deep
// - start low with chip select low begins conversion
// - starts during a conversion are ignored
// - status low throughout conversion, high after
// - falling start edge starts, either pulse polarity
// - select and read low keep outputs driven
// - separate read strobe enables outputs only while low
// - previous result shown until conversion completes
// - slow memory host waits status high, then reads
// - rom read returns previous result, starts new
// - shared strobe, select low, no sample clock
// - result is 12-bit two's complement, 4096 steps
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          RESULT_W    = 12;
  localparam int          RESULT_STEPS = 4096;
  localparam logic [11:0] RESULT_RST  = 12'h000;
  localparam int          DEV_PIN_W   = 5;
  localparam logic [4:0]  DEV_PIN_RST = 5'h1f;
  localparam int          HOST_PIN_W  = 13;
  localparam logic [12:0] HOST_PIN_RST = 13'h1000;

  // ----------------------------------------------------------------
  // timing, in ns except the deep wake in ms, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CONV_TYP_NS    = 650;
  localparam int CONV_MAX_NS    = 750;
  localparam int ACQ_MAX_NS     = 100;
  localparam int THROUGHPUT_NS  = 800;
  localparam int NAP_WAKE_NS    = 200;
  localparam int SLEEP_WAKE_MS  = 10;
  // conversion rounds the typical figure up; it still fits the maximum
  localparam int CONV_CYC       = (CONV_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC   = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC        = (ACQ_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  ACQ_MAX_NS / CLK_PERIOD_NS;
  localparam int THROUGHPUT_CYC = THROUGHPUT_NS / CLK_PERIOD_NS;
  localparam int NAP_WAKE_CYC   = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W     = 24;

  // host side handshaking counts
  localparam int STROBE_CYC     = 2;
  localparam int READ_CYC       = 8;
  localparam int LINK_LAT_CYC   = 4;

  // ----------------------------------------------------------------
  // operating styles seen from the host
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_FREE_LOW_PULSE,
    MODE_FREE_HIGH_PULSE,
    MODE_BUS_READ,
    MODE_SLOW_MEMORY,
    MODE_ROM
  } host_mode_t;

endpackage : adc_ctl_pkg

// ===== logic/adc_device_end.sv
/*
  converter end: start detection, conversion timing, status, result
  output enables and the two shutdown levels.
  assumes the host keeps its own wake-up waits and strobe ordering.
*/
`timescale 1ns/1ns
module adc_device_end
  import adc_ctl_pkg::*;
#(
  parameter int SLEEP_WAKE_CYCLES = adc_ctl_pkg::SLEEP_WAKE_CYC
) (
  // clock and control
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // pins toward the host
  adc_link_if.device               link,
  // analog side, already digitised as two's complement
  input  wire logic [11:0]         i_sample,
  // user side status
  output logic [11:0]              o_result,
  output logic                     o_result_valid,
  output logic                     o_converting,
  output logic                     o_analog_on,
  output logic                     o_reference_on,
  output logic                     o_shutdown_light,
  output logic                     o_shutdown_deep
);
  import adc_ctl_pkg::*;

  // ----------------------------------------------------------------
  // pin filtering
  // ----------------------------------------------------------------
  logic [DEV_PIN_W-1:0] pins_q;
  logic                 start_n_s;
  logic                 cs_n_s;
  logic                 rd_n_s;
  logic                 pd_n_s;
  logic                 level_s;

  pin_filter #(
    .W       (DEV_PIN_W),
    .RST_VAL (DEV_PIN_RST)
  ) u_pins (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_d    ({link.conversion_start_n, link.chip_select_n, link.read_n,
              link.power_down_n, link.shutdown_level_select}),
    .o_q    (pins_q)
  );

  assign start_n_s = pins_q[4];
  assign cs_n_s    = pins_q[3];
  assign rd_n_s    = pins_q[2];
  assign pd_n_s    = pins_q[1];
  assign level_s   = pins_q[0];

  // ----------------------------------------------------------------
  // start edge
  // ----------------------------------------------------------------
  logic start_prev_r;
  logic start_fall;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      start_prev_r <= 1'b1;
    else if (i_ce)
      start_prev_r <= start_n_s;
  end

  // only a falling edge counts, so either pulse polarity works
  assign start_fall = start_prev_r & ~start_n_s;

  // ----------------------------------------------------------------
  // conversion and power sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_ACQ,
    ST_DOWN,
    ST_WAKE
  } dev_state_t;

  dev_state_t              state_r;
  dev_state_t              state_nxt;
  logic [WAKE_CNT_W-1:0]   cnt_r;
  logic [WAKE_CNT_W-1:0]   cnt_nxt;
  logic [11:0]             hold_r;
  logic [11:0]             result_r;
  logic [11:0]             result_nxt;
  logic                    level_r;
  logic                    level_nxt;
  logic                    done;

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    result_nxt = result_r;
    level_nxt  = level_r;
    done       = 1'b0;
    if (!pd_n_s && state_r != ST_DOWN)
    begin
      state_nxt = ST_DOWN;
      level_nxt = level_s;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // starts are taken here or in the last acquisition cycle, never while converting
          if (start_fall && !cs_n_s)
          begin
            state_nxt = ST_CONV;
            cnt_nxt   = WAKE_CNT_W'(CONV_CYC - 1);
          end
        end
        ST_CONV:
        begin
          if (cnt_r == '0)
          begin
            state_nxt  = ST_ACQ;
            cnt_nxt    = WAKE_CNT_W'(ACQ_CYC - 1);
            result_nxt = hold_r;
            done       = 1'b1;
          end
          else
            cnt_nxt = cnt_r - 1'b1;
        end
        ST_ACQ:
        begin
          // conversion plus acquisition spans the full throughput slot; a start
          // seen in the last acquisition cycle is taken at once, else it would slip
          if (cnt_r == '0)
          begin
            state_nxt = ST_IDLE;
            if (start_fall && !cs_n_s)
            begin
              state_nxt = ST_CONV;
              cnt_nxt   = WAKE_CNT_W'(CONV_CYC - 1);
            end
          end
          else
            cnt_nxt = cnt_r - 1'b1;
        end
        ST_DOWN:
        begin
          level_nxt = level_s;
          if (pd_n_s)
          begin
            state_nxt = ST_WAKE;
            cnt_nxt   = level_r ? WAKE_CNT_W'(NAP_WAKE_CYC - 1)
                                : WAKE_CNT_W'(SLEEP_WAKE_CYCLES - 1);
          end
        end
        ST_WAKE:
        begin
          // starts that arrive before this end's own wake count has run out are dropped
          if (cnt_r == '0)
            state_nxt = ST_IDLE;
          else
            cnt_nxt = cnt_r - 1'b1;
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      result_r <= RESULT_RST;
      level_r  <= 1'b1;
    end
    else if (i_ce)
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      result_r <= result_nxt;
      level_r  <= level_nxt;
    end
  end

  // sample is held at the start edge, like the track-and-hold
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      hold_r <= RESULT_RST;
    else if (i_ce && state_r != ST_CONV && state_nxt == ST_CONV)
      hold_r <= i_sample;
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  logic        busy_n_r;
  logic [11:0] data_r;
  logic        data_oe_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      busy_n_r  <= 1'b1;
      data_r    <= RESULT_RST;
      data_oe_r <= 1'b0;
    end
    else if (i_ce)
    begin
      busy_n_r  <= (state_nxt != ST_CONV);
      // new data lands on the same edge that status returns high
      data_r    <= result_nxt;
      // select and read both low: driven; tied low means always driven
      data_oe_r <= !cs_n_s && !rd_n_s;
    end
  end

  assign link.busy_n   = busy_n_r;
  assign link.data_out = data_r;
  assign link.data_oe  = data_oe_r;

  // ----------------------------------------------------------------
  // user side status
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_result         <= RESULT_RST;
      o_result_valid   <= 1'b0;
      o_converting     <= 1'b0;
      o_analog_on      <= 1'b1;
      o_reference_on   <= 1'b1;
      o_shutdown_light <= 1'b0;
      o_shutdown_deep  <= 1'b0;
    end
    else if (i_ce)
    begin
      o_result         <= result_nxt;
      o_result_valid   <= done;
      o_converting     <= (state_nxt == ST_CONV);
      o_analog_on      <= (state_nxt != ST_DOWN);
      // light level drops roughly 95% of power but keeps the reference alive
      o_reference_on   <= !(state_nxt == ST_DOWN && !level_nxt);
      o_shutdown_light <= (state_nxt == ST_DOWN) && level_nxt;
      o_shutdown_deep  <= (state_nxt == ST_DOWN) && !level_nxt;
    end
  end

endmodule : adc_device_end

// ===== logic/adc_host_end.sv
/*
  host end: drives select, start, read and shutdown pins in one of five
  operating styles and collects results.
  assumes the converter end follows the status and data timing of the link.
*/
`timescale 1ns/1ns
module adc_host_end
  import adc_ctl_pkg::*;
#(
  parameter int SLEEP_WAKE_CYCLES = adc_ctl_pkg::SLEEP_WAKE_CYC
) (
  // clock and control
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  // pins toward the converter
  adc_link_if.host                   link,
  // user requests
  input  wire adc_ctl_pkg::host_mode_t i_mode,
  input  wire logic                  i_start,
  input  wire logic                  i_power_down,
  input  wire logic                  i_shutdown_light,
  // user results
  output logic [11:0]                o_result,
  output logic                       o_result_valid,
  output logic                       o_ready
);
  import adc_ctl_pkg::*;

  // resting level of the start pin; the high-pulse style rests low
  function automatic logic start_idle(input host_mode_t m);
    start_idle = (m != MODE_FREE_HIGH_PULSE);
  endfunction : start_idle

  function automatic logic shared_strobe(input host_mode_t m);
    shared_strobe = (m == MODE_SLOW_MEMORY) || (m == MODE_ROM);
  endfunction : shared_strobe

  // ----------------------------------------------------------------
  // pin filtering
  // ----------------------------------------------------------------
  logic [HOST_PIN_W-1:0] pins_q;

  pin_filter #(
    .W       (HOST_PIN_W),
    .RST_VAL (HOST_PIN_RST)
  ) u_pins (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_d    ({link.busy_n, link.data_out}),
    .o_q    (pins_q)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE,
    H_PULSE,
    H_BUSY_LO,
    H_BUSY_HI,
    H_READ,
    H_OFF,
    H_WAKE
  } host_state_t;

  host_state_t           state_r;
  host_mode_t            mode_r;
  logic [WAKE_CNT_W-1:0] cnt_r;
  logic                  start_n_r;
  logic                  cs_n_r;
  logic                  rd_n_r;
  logic                  pd_n_r;
  logic                  level_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_r        <= H_IDLE;
      mode_r         <= MODE_FREE_LOW_PULSE;
      cnt_r          <= '0;
      start_n_r      <= 1'b1;
      cs_n_r         <= 1'b1;
      rd_n_r         <= 1'b1;
      pd_n_r         <= 1'b1;
      level_r        <= 1'b1;
      o_result       <= RESULT_RST;
      o_result_valid <= 1'b0;
      o_ready        <= 1'b0;
    end
    else if (i_ce)
    begin
      o_result_valid <= 1'b0;
      o_ready        <= 1'b0;
      cs_n_r         <= 1'b0;
      case (state_r)
        H_IDLE:
        begin
          mode_r    <= i_mode;
          start_n_r <= start_idle(i_mode);
          // shared strobe styles rest read high together with start
          rd_n_r    <= (i_mode == MODE_BUS_READ) || shared_strobe(i_mode);
          o_ready   <= !i_start && !i_power_down;
          if (i_power_down)
          begin
            pd_n_r  <= 1'b0;
            level_r <= i_shutdown_light;
            state_r <= H_OFF;
          end
          else if (i_start)
          begin
            start_n_r <= !start_idle(i_mode);
            if (shared_strobe(i_mode))
            begin
              // start and read move together as one strobe
              rd_n_r  <= 1'b0;
              state_r <= H_BUSY_LO;
            end
            else
            begin
              cnt_r   <= WAKE_CNT_W'(STROBE_CYC - 1);
              state_r <= H_PULSE;
            end
          end
        end
        H_PULSE:
        begin
          if (cnt_r == '0)
          begin
            start_n_r <= start_idle(mode_r);
            state_r   <= H_BUSY_LO;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        H_BUSY_LO:
        begin
          if (!pins_q[12])
          begin
            state_r <= H_BUSY_HI;
            if (mode_r == MODE_ROM)
            begin
              // previous result is still on the pins while converting
              o_result       <= pins_q[11:0];
              o_result_valid <= 1'b1;
              start_n_r      <= 1'b1;
              rd_n_r         <= 1'b1;
            end
          end
        end
        H_BUSY_HI:
        begin
          if (pins_q[12])
          begin
            state_r <= H_IDLE;
            case (mode_r)
              MODE_BUS_READ:
              begin
                rd_n_r  <= 1'b0;
                cnt_r   <= WAKE_CNT_W'(READ_CYC - 1);
                state_r <= H_READ;
              end
              MODE_SLOW_MEMORY:
              begin
                o_result       <= pins_q[11:0];
                o_result_valid <= 1'b1;
                start_n_r      <= 1'b1;
                rd_n_r         <= 1'b1;
              end
              MODE_ROM:
                state_r <= H_IDLE;
              default:
              begin
                // status rising edge latches the result
                o_result       <= pins_q[11:0];
                o_result_valid <= 1'b1;
              end
            endcase
          end
        end
        H_READ:
        begin
          if (cnt_r == '0)
          begin
            o_result       <= pins_q[11:0];
            o_result_valid <= 1'b1;
            rd_n_r         <= 1'b1;
            state_r        <= H_IDLE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        H_OFF:
        begin
          level_r <= i_shutdown_light;
          if (!i_power_down)
          begin
            pd_n_r  <= 1'b1;
            // margin covers the far end's input filter delay
            cnt_r   <= level_r ? WAKE_CNT_W'(NAP_WAKE_CYC + LINK_LAT_CYC)
                               : WAKE_CNT_W'(SLEEP_WAKE_CYCLES + LINK_LAT_CYC);
            state_r <= H_WAKE;
          end
        end
        H_WAKE:
        begin
          if (cnt_r == '0)
            state_r <= H_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default:
          state_r <= H_IDLE;
      endcase
    end
  end

  assign link.conversion_start_n    = start_n_r;
  assign link.chip_select_n         = cs_n_r;
  assign link.read_n                = rd_n_r;
  assign link.power_down_n          = pd_n_r;
  assign link.shutdown_level_select = level_r;

endmodule : adc_host_end

// ===== logic/adc_link_if.sv
/*
  pin bundle between the converter end and its host end.
  assumes the testbench resolves the data wires from data_oe.
*/
`timescale 1ns/1ns
interface adc_link_if;
  logic        conversion_start_n;
  logic        chip_select_n;
  logic        read_n;
  logic        power_down_n;
  logic        shutdown_level_select;
  logic        busy_n;
  logic [11:0] data_out;
  logic        data_oe;

  modport device (
    input  conversion_start_n, chip_select_n, read_n, power_down_n,
    input  shutdown_level_select,
    output busy_n, data_out, data_oe
  );

  modport host (
    output conversion_start_n, chip_select_n, read_n, power_down_n,
    output shutdown_level_select,
    input  busy_n, data_out, data_oe
  );
endinterface : adc_link_if

// ===== logic/pin_filter.sv
/*
  three-flop input filter for signals arriving from the far end.
  assumes one clock; a bit changes only once stages two and three agree.
*/
`timescale 1ns/1ns
module pin_filter #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  // clock and control
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  // data
  input  wire logic [W-1:0]  i_d,
  output logic      [W-1:0]  o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      o_q  <= RST_VAL;
    end
    else if (i_ce)
    begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // per bit: follow when stages agree, otherwise hold
      o_q  <= (s2_r & ~(s2_r ^ s3_r)) | (o_q & (s2_r ^ s3_r));
    end
  end
endmodule : pin_filter
